// ### design/phy_data_port.sv
// MAC-facing MII / RMII data port of a 10/100 transceiver, AXI4-Lite regs.
// Assumes a line core on the same clock supplies decoded receive nibbles
// and carrier events, and consumes transmit nibbles as strobes.
//
// Notes on behaviour
// - Strap 000 captured after reset selects the 4-bit MII mode.
// - MII transmit and receive are independent 4-bit paths.
// - TXC is generated free-running, 2.5 or 25 MHz by speed.
// - TXD is taken only while TXEN is high; otherwise ignored.
// - RXC follows line clock when carrier or 100M link, else local.
// - At 10M, RXDV rises on first SFD nibble, holds to frame end.
// - At 100M, RXDV covers first preamble nibble to last nibble.
// - Each RXC period with RXDV high carries one nibble on RXD.
// - RXER marks a symbol error for at least one RXC period.
// - At 10M, CRS rises on valid preamble, falls on end marker.
// - At 100M, CRS rises on J/K, falls on T/R or bare idle.
// - COL shows half-duplex overlap of transmit and receive.
// - Strap 001 with clock-mode bit 0 selects RMII 25 MHz mode.
// - Strap 001 with clock-mode bit 1 selects RMII 50 MHz mode.
// - All RMII signals are timed to one 50 MHz reference clock.
// - 25 MHz mode drives REF_CLK out; 50 MHz mode takes it in.
// - RMII TXD is taken only while TX_EN is high.
// - CRS_DV rises at once on carrier detect, falls on carrier loss.
// - CRS_DV covers first to last dibit, drops after the final one.
// - RXD reads 00 after CRS_DV rises until data is decoded.
// - Each reference period with CRS_DV high carries one dibit.
// - RX_ER marks a symbol error for at least one reference period.
`timescale 1ns/100ps
module phy_data_port
	import phy_port_pkg::*;
(
	input  wire logic            I_CLK,
	input  wire logic            I_RST_N,
	input  wire logic            I_CE,
	// Pins from the MAC side and board
	input  wire logic [2:0]      I_CONFIG,
	input  wire logic            I_CRYSTAL_CLOCK_INPUT,
	input  wire logic            I_TXEN,
	input  wire logic [3:0]      I_TXD,
	output logic                 O_TXC,
	output logic                 O_RXC,
	output logic                 O_RXDV,
	output logic [3:0]           O_RXD,
	output logic                 O_RXER,
	output logic                 O_CRS,
	output logic                 O_COL,
	output logic                 O_CRS_DV,
	output logic                 O_REF_CLK,
	output logic                 O_REF_CLK_OE,
	// Line core side
	input  wire logic            I_LINE_RXCLK,
	input  wire line_status_type I_LINE_STATUS,
	input  wire line_rx_type     I_LINE_RX,
	output line_tx_type          O_LINE_TX,
	// AXI4-Lite slave
	input  wire logic [11:0]     S_AXI_AWADDR,
	input  wire logic            S_AXI_AWVALID,
	output logic                 S_AXI_AWREADY,
	input  wire logic [31:0]     S_AXI_WDATA,
	input  wire logic [3:0]      S_AXI_WSTRB,
	input  wire logic            S_AXI_WVALID,
	output logic                 S_AXI_WREADY,
	output logic [1:0]           S_AXI_BRESP,
	output logic                 S_AXI_BVALID,
	input  wire logic            S_AXI_BREADY,
	input  wire logic [11:0]     S_AXI_ARADDR,
	input  wire logic            S_AXI_ARVALID,
	output logic                 S_AXI_ARREADY,
	output logic [31:0]          S_AXI_RDATA,
	output logic [1:0]           S_AXI_RRESP,
	output logic                 S_AXI_RVALID,
	input  wire logic            S_AXI_RREADY
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [1:0]   strap_cnt;
		logic         strap_done;
		logic [2:0]   strap;
		logic         mode50;
		logic         aw_got;
		logic [11:0]  aw_addr;
		logic         w_got;
		logic [31:0]  wdata;
		logic         wstrb0;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
		logic         crs;
		logic         car100;
		logic         col;
		logic         tx_active;
		logic         tx_half;
		logic [3:0]   tx_rep;
		logic [1:0]   tx_dibit;
		line_tx_type  line_tx;
		logic         hold_valid;
		logic         hold_sfd;
		logic         hold_err;
		logic [3:0]   hold_data;
		rx_state_type rx_state;
		logic [3:0]   cur_nib;
		logic         cur_err;
		logic         rx_half;
		logic [3:0]   rx_rep;
		logic         rxdv;
		logic [3:0]   rxd;
		logic         rxer;
		logic         crs_dv;
		logic         rxc;
	} port_state_type;

	port_state_type r_reg;
	port_state_type r_next;

	logic [SYNC_W-1:0] pin_level;
	logic [SYNC_W-1:0] pin_rise;
	logic [SYNC_W-1:0] pin_fall;
	logic              txc_level;
	logic              txc_rise;
	logic              txc_fall;
	logic              refdiv_level;
	logic              refdiv_rise;
	logic              refdiv_fall;
	logic              rmii;
	logic              speed100;
	logic              ref_rise;
	logic              ref_fall;
	logic              use_line_clk;
	logic              rxc_rise;
	logic              rmii_carrier;
	logic [31:0]       status_word;

	function automatic logic [1:0] reg_decode(input logic [11:0] addr);
		if (addr == STATUS_ADDR) begin
			return SEL_STATUS;
		end else if (addr == CTRL_ADDR) begin
			return SEL_CTRL;
		end
		return SEL_NONE;
	endfunction : reg_decode

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and clock generators
	phy_in_sync u_sync (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_ce    (I_CE),
		.i_async ({I_LINE_RXCLK, I_CRYSTAL_CLOCK_INPUT, I_CONFIG, I_TXD,
		           I_TXEN}),
		.o_level (pin_level),
		.o_rise  (pin_rise),
		.o_fall  (pin_fall)
	);

	assign speed100 = I_LINE_STATUS.speed100;

	// Free-running transmit clock, also the local receive clock
	phy_clk_divider u_txc_div (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_ce    (I_CE),
		.i_half  (speed100 ? MII_FAST_HALF : MII_SLOW_HALF),
		.o_level (txc_level),
		.o_rise  (txc_rise),
		.o_fall  (txc_fall)
	);

	phy_clk_divider u_ref_div (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_ce    (I_CE),
		.i_half  (REF_HALF),
		.o_level (refdiv_level),
		.o_rise  (refdiv_rise),
		.o_fall  (refdiv_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode and timing selection
	assign rmii = r_reg.strap_done && (r_reg.strap == STRAP_RMII);
	// External reference edges in 50 MHz mode, own divider otherwise
	assign ref_rise = r_reg.mode50 ? pin_rise[SY_XTAL] : refdiv_rise;
	assign ref_fall = r_reg.mode50 ? pin_fall[SY_XTAL] : refdiv_fall;
	assign use_line_clk = I_LINE_STATUS.link_up &&
		(speed100 || r_reg.crs);
	assign rxc_rise = use_line_clk ? pin_rise[SY_RXCLK] : txc_rise;
	assign rmii_carrier = speed100 ? r_reg.car100 : I_LINE_RX.squelch;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_STRAP_LSB +: 3] = r_reg.strap;
		status_word[ST_RMII]      = rmii;
		status_word[ST_MODE50]    = r_reg.mode50;
		status_word[ST_SPEED100]  = speed100;
		status_word[ST_FULL_DUP]  = I_LINE_STATUS.full_duplex;
		status_word[ST_LINK]      = I_LINE_STATUS.link_up;
		status_word[ST_CRS]       = r_reg.crs;
		status_word[ST_TX_ACTIVE] = r_reg.tx_active;
		status_word[ST_RX_ACTIVE] = (r_reg.rx_state != RX_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.line_tx.stb = 1'b0;

		// Strap is caught once the synchroniser has settled after reset
		if (!r_reg.strap_done) begin
			r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
			if (r_reg.strap_cnt == STRAP_SETTLE) begin
				r_next.strap      = pin_level[SY_CFG +: 3];
				r_next.strap_done = 1'b1;
			end
		end

		// Register writes: address and data in either order
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			r_next.aw_got  = 1'b1;
			r_next.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			r_next.w_got  = 1'b1;
			r_next.wdata  = S_AXI_WDATA;
			r_next.wstrb0 = S_AXI_WSTRB[0];
		end
		if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = RESP_OKAY;
			case (reg_decode(r_reg.aw_addr))
				SEL_CTRL: begin
					if (r_reg.wstrb0) begin
						r_next.mode50 = r_reg.wdata[CTRL_CLK_MODE_BIT];
					end
				end
				SEL_STATUS: begin
					r_next.bresp = RESP_OKAY;
				end
				default: begin
					r_next.bresp = RESP_SLVERR;
				end
			endcase
		end else if (r_reg.bvalid && S_AXI_BREADY) begin
			r_next.bvalid = 1'b0;
		end

		// Register reads
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = RESP_OKAY;
			r_next.rdata  = 32'h0000_0000;
			case (reg_decode(S_AXI_ARADDR))
				SEL_STATUS: begin
					r_next.rdata = status_word;
				end
				SEL_CTRL: begin
					r_next.rdata[CTRL_CLK_MODE_BIT] = r_reg.mode50;
				end
				default: begin
					r_next.rresp = RESP_SLVERR;
				end
			endcase
		end else if (r_reg.rvalid && S_AXI_RREADY) begin
			r_next.rvalid = 1'b0;
		end

		// Carrier sense; link loss clears, else a set in the same cycle beats a clear
		if (!I_LINE_STATUS.link_up) begin
			r_next.crs    = 1'b0;
			r_next.car100 = 1'b0;
		end else if (speed100) begin
			if (I_LINE_RX.tr || I_LINE_RX.idle) begin
				r_next.crs    = 1'b0;
				r_next.car100 = 1'b0;
			end
			if (I_LINE_RX.jk) begin
				r_next.crs = 1'b1;
			end
			if (I_LINE_RX.two_zeros) begin
				r_next.car100 = 1'b1;
			end
		end else begin
			if (I_LINE_RX.eof) begin
				r_next.crs = 1'b0;
			end
			if (I_LINE_RX.preamble) begin
				r_next.crs = 1'b1;
			end
		end

		// Transmit: sample mid-period, away from the MAC's change edge
		if (!rmii) begin
			if (txc_fall) begin
				r_next.tx_active = pin_level[SY_TXEN];
				if (pin_level[SY_TXEN]) begin
					r_next.line_tx.stb  = 1'b1;
					r_next.line_tx.data = pin_level[SY_TXD +: 4];
				end
			end
		end else if (ref_fall) begin
			if (!pin_level[SY_TXEN]) begin
				r_next.tx_active = 1'b0;
				r_next.tx_half   = 1'b0;
				r_next.tx_rep    = 4'h0;
			end else if (speed100 || r_reg.tx_rep == 4'h0) begin
				// First sample at TX_EN rise, then once per ten at 10M
				r_next.tx_active = 1'b1;
				r_next.tx_half   = ~r_reg.tx_half;
				if (!r_reg.tx_half) begin
					r_next.tx_dibit = pin_level[SY_TXD +: 2];
				end else begin
					r_next.line_tx.stb  = 1'b1;
					r_next.line_tx.data = {pin_level[SY_TXD +: 2],
						r_reg.tx_dibit};
				end
			end
			if (pin_level[SY_TXEN] && !speed100) begin
				r_next.tx_rep = (r_reg.tx_rep == RMII_SLOW_REPEAT - 4'h1) ?
					4'h0 : r_reg.tx_rep + 4'h1;
			end
		end
		r_next.line_tx.active = r_next.tx_active;

		// Receive, MII: one nibble per RXC period
		if (!rmii) begin
			r_next.crs_dv = 1'b0;
			if (rxc_rise) begin
				r_next.rxer = 1'b0;
				case (r_reg.rx_state)
					RX_DATA: begin
						if (r_reg.hold_valid) begin
							r_next.rxd        = r_reg.hold_data;
							r_next.rxer       = r_reg.hold_err;
							r_next.hold_valid = 1'b0;
						end else if (!r_reg.crs) begin
							r_next.rxdv     = 1'b0;
							r_next.rxd      = 4'h0;
							r_next.rx_state = RX_IDLE;
						end
					end
					default: begin
						r_next.rxdv = 1'b0;
						r_next.rxd  = 4'h0;
						r_next.rx_state = RX_IDLE;
						if (r_reg.hold_valid) begin
							r_next.hold_valid = 1'b0;
							// Preamble nibbles before SFD are dropped at 10M
							if (speed100 || r_reg.hold_sfd) begin
								r_next.rxdv     = 1'b1;
								r_next.rxd      = r_reg.hold_data;
								r_next.rxer     = r_reg.hold_err;
								r_next.rx_state = RX_DATA;
							end
						end
					end
				endcase
			end
		end else begin
			r_next.rxdv = 1'b0;
			// Receive, RMII: CRS_DV rises without waiting for a clock edge
			if (r_reg.rx_state == RX_IDLE && rmii_carrier) begin
				r_next.crs_dv   = 1'b1;
				r_next.rxd      = 4'h0;
				r_next.rx_state = RX_WAIT;
				r_next.rx_rep   = 4'h0;
			end else if (ref_rise && (speed100 || r_reg.rx_rep == 4'h0)) begin
				case (r_reg.rx_state)
					RX_WAIT, RX_DATA: begin
						if (r_reg.rx_half) begin
							r_next.rxd     = {2'h0, r_reg.cur_nib[3:2]};
							r_next.rx_half = 1'b0;
						end else if (r_reg.hold_valid) begin
							r_next.cur_nib    = r_reg.hold_data;
							r_next.cur_err    = r_reg.hold_err;
							r_next.hold_valid = 1'b0;
							r_next.rxd        = {2'h0, r_reg.hold_data[1:0]};
							r_next.rxer       = r_reg.hold_err;
							r_next.rx_half    = 1'b1;
							r_next.rx_state   = RX_DATA;
						end else if (!rmii_carrier) begin
							r_next.crs_dv   = 1'b0;
							r_next.rxd      = 4'h0;
							r_next.rxer     = 1'b0;
							r_next.rx_state = RX_IDLE;
						end else begin
							r_next.rxd  = 4'h0;
							r_next.rxer = 1'b0;
						end
					end
					default: begin
						r_next.crs_dv = 1'b0;
						r_next.rxd    = 4'h0;
						r_next.rxer   = 1'b0;
					end
				endcase
			end
			if (ref_rise && !speed100 && r_reg.rx_state != RX_IDLE) begin
				r_next.rx_rep = (r_reg.rx_rep == RMII_SLOW_REPEAT - 4'h1) ?
					4'h0 : r_reg.rx_rep + 4'h1;
			end
		end

		// Newest line nibble overwrites any unconsumed one
		if (I_LINE_RX.valid) begin
			r_next.hold_valid = 1'b1;
			r_next.hold_data  = I_LINE_RX.data;
			r_next.hold_sfd   = I_LINE_RX.sfd;
			r_next.hold_err   = I_LINE_RX.err;
		end

		// Collision needs no clock alignment; RMII has no such pin
		r_next.col = !rmii && !I_LINE_STATUS.full_duplex &&
			pin_level[SY_TXEN] && r_reg.crs;
		// Clock source switch may stretch one RXC phase
		r_next.rxc = use_line_clk ? pin_level[SY_RXCLK] : txc_level;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			r_reg        <= '0;
			r_reg.mode50 <= CTRL_CLK_MODE_RESET;
		end else if (I_CE) begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign O_TXC        = txc_level && !rmii;
	assign O_RXC        = r_reg.rxc && !rmii;
	assign O_RXDV       = r_reg.rxdv;
	assign O_RXD        = r_reg.rxd;
	assign O_RXER       = r_reg.rxer;
	assign O_CRS        = r_reg.crs && !rmii;
	assign O_COL        = r_reg.col;
	assign O_CRS_DV     = r_reg.crs_dv;
	assign O_REF_CLK    = refdiv_level && rmii && !r_reg.mode50;
	assign O_REF_CLK_OE = rmii && !r_reg.mode50;
	assign O_LINE_TX    = r_reg.line_tx;

	assign S_AXI_AWREADY = !r_reg.aw_got && !r_reg.bvalid;
	assign S_AXI_WREADY  = !r_reg.w_got && !r_reg.bvalid;
	assign S_AXI_BVALID  = r_reg.bvalid;
	assign S_AXI_BRESP   = r_reg.bresp;
	assign S_AXI_ARREADY = !r_reg.rvalid;
	assign S_AXI_RVALID  = r_reg.rvalid;
	assign S_AXI_RDATA   = r_reg.rdata;
	assign S_AXI_RRESP   = r_reg.rresp;

endmodule : phy_data_port

// ### design/phy_port_pkg.sv
// Shared constants, field layouts and state types of the PHY data port.
// Assumes one 200 MHz core clock; all half periods derive from its rate.
package phy_port_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock rates and derived half periods in core cycles
	localparam int CLK_FREQ_HZ = 200_000_000;
	localparam int MII_FAST_HZ = 25_000_000;
	localparam int MII_SLOW_HZ = 2_500_000;
	localparam int REF_CLK_HZ  = 50_000_000;
	localparam logic [6:0] MII_FAST_HALF = 7'(CLK_FREQ_HZ / (2 * MII_FAST_HZ));
	localparam logic [6:0] MII_SLOW_HALF = 7'(CLK_FREQ_HZ / (2 * MII_SLOW_HZ));
	localparam logic [6:0] REF_HALF      = 7'(CLK_FREQ_HZ / (2 * REF_CLK_HZ));
	localparam logic [3:0] RMII_SLOW_REPEAT = 4'hA;
	localparam logic [1:0] STRAP_SETTLE     = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Strap codes and register map
	localparam logic [2:0]  STRAP_MII  = 3'h0;
	localparam logic [2:0]  STRAP_RMII = 3'h1;
	localparam logic [7:0]  CTRL_IDX   = 8'h1F;
	localparam logic [11:0] CTRL_ADDR  = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] STATUS_ADDR = 12'h000;
	localparam int CTRL_CLK_MODE_BIT = 7;
	localparam logic CTRL_CLK_MODE_RESET = 1'b0;
	localparam int ST_STRAP_LSB = 0;
	localparam int ST_RMII      = 3;
	localparam int ST_MODE50    = 4;
	localparam int ST_SPEED100  = 5;
	localparam int ST_FULL_DUP  = 6;
	localparam int ST_LINK      = 7;
	localparam int ST_CRS       = 8;
	localparam int ST_TX_ACTIVE = 9;
	localparam int ST_RX_ACTIVE = 10;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SEL_NONE   = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_CTRL   = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Positions inside the synchronised pin vector
	localparam int SYNC_W   = 10;
	localparam int SY_TXEN  = 0;
	localparam int SY_TXD   = 1;
	localparam int SY_CFG   = 5;
	localparam int SY_XTAL  = 8;
	localparam int SY_RXCLK = 9;

	////////////////////////////////////////////////////////////////////////
	// Carriers and state
	typedef struct packed {
		logic       link_up;
		logic       speed100;
		logic       full_duplex;
	} line_status_type;

	typedef struct packed {
		logic       squelch;
		logic       preamble;
		logic       eof;
		logic       two_zeros;
		logic       jk;
		logic       tr;
		logic       idle;
		logic       valid;
		logic       sfd;
		logic       err;
		logic [3:0] data;
	} line_rx_type;

	typedef struct packed {
		logic       stb;
		logic       active;
		logic [3:0] data;
	} line_tx_type;

	typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_DATA} rx_state_type;

	typedef struct packed {
		logic [6:0] cnt;
		logic       level;
		logic       rise;
		logic       fall;
	} div_state_type;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] stable;
		logic [SYNC_W-1:0] last;
	} sync_state_type;

endpackage : phy_port_pkg

// ### design/phy_clk_divider.sv
// Square-wave divider with one-cycle rise and fall pulses.
// Assumes i_half is at least 1 and changes only between frames.
`timescale 1ns/100ps
module phy_clk_divider
	import phy_port_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic [6:0] i_half,
	output logic            o_level,
	output logic            o_rise,
	output logic            o_fall
);

	div_state_type st_reg;
	div_state_type st_next;

	always_comb begin
		st_next = st_reg;
		st_next.rise = 1'b0;
		st_next.fall = 1'b0;
		// Compare with >= so a shorter half period takes effect at once
		if (st_reg.cnt >= i_half - 7'h1) begin
			st_next.cnt   = 7'h00;
			st_next.level = ~st_reg.level;
			st_next.rise  = ~st_reg.level;
			st_next.fall  = st_reg.level;
		end else begin
			st_next.cnt = st_reg.cnt + 7'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.level;
	assign o_rise  = st_reg.rise;
	assign o_fall  = st_reg.fall;

endmodule : phy_clk_divider

// ### design/phy_in_sync.sv
// Two-stage synchroniser for all pin inputs, with edge pulses.
// Assumes inputs are asynchronous levels; edges seen 2 to 3 cycles late.
`timescale 1ns/100ps
module phy_in_sync
	import phy_port_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire logic [SYNC_W-1:0] i_async,
	output logic      [SYNC_W-1:0] o_level,
	output logic      [SYNC_W-1:0] o_rise,
	output logic      [SYNC_W-1:0] o_fall
);

	sync_state_type st_reg;
	sync_state_type st_next;

	always_comb begin
		st_next        = st_reg;
		st_next.meta   = i_async;
		st_next.stable = st_reg.meta;
		st_next.last   = st_reg.stable;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	// Only the second stage and later feed logic
	assign o_level = st_reg.stable;
	assign o_rise  = st_reg.stable & ~st_reg.last;
	assign o_fall  = ~st_reg.stable & st_reg.last;

endmodule : phy_in_sync

// ### testbench/phy_data_port_asserts.sv
// Pin and register-bus assertions of the PHY data port.
// Assumes I_CE stays high; bound to every port instance.
`timescale 1ns/100ps
module phy_data_port_asserts
	import phy_port_pkg::*;
(
	input wire logic            I_CLK,
	input wire logic            I_RST_N,
	input wire line_status_type I_LINE_STATUS,
	input wire line_rx_type     I_LINE_RX,
	input wire logic            O_TXC,
	input wire logic            O_CRS,
	input wire logic            O_COL,
	input wire logic            O_CRS_DV,
	input wire logic [3:0]      O_RXD,
	input wire logic            O_REF_CLK,
	input wire logic            O_REF_CLK_OE,
	input wire logic            S_AXI_ARVALID,
	input wire logic            S_AXI_ARREADY,
	input wire logic            S_AXI_RVALID
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_ref_up;
		$rose(O_REF_CLK) && O_REF_CLK_OE;
	endsequence
	sequence s_rd_taken;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_col_half: assert property (
		O_COL |-> !$past(I_LINE_STATUS.full_duplex))
		else $error("collision in full duplex");
	// One cycle of grace while the mode switches
	a_rmii_quiet: assert property (
		O_REF_CLK_OE && $past(O_REF_CLK_OE)
		|-> !O_TXC && !O_CRS && !O_COL)
		else $error("mii pins active in rmii");
	a_ref_period: assert property (
		s_ref_up |-> ##4 ($rose(O_REF_CLK) || !O_REF_CLK_OE))
		else $error("ref clock period wrong");
	// Driven reference holds each level for exactly two cycles
	a_ref_toggle: assert property (
		O_REF_CLK_OE && $past(O_REF_CLK_OE) && $stable(O_REF_CLK)
		|=> $changed(O_REF_CLK) || !O_REF_CLK_OE)
		else $error("ref clock stuck");
	a_rxd_idle: assert property (
		O_REF_CLK_OE && !O_CRS_DV |-> O_RXD == 4'h0)
		else $error("rxd not idle");
	a_dv_zero: assert property (
		$rose(O_CRS_DV) |-> O_RXD == 4'h0)
		else $error("rxd not zero at dv rise");
	a_carrier_dv: assert property (
		I_LINE_RX.two_zeros && I_LINE_STATUS.speed100 && O_REF_CLK_OE
		|-> ##[1:2] O_CRS_DV)
		else $error("crs_dv late");
	a_rd_answer: assert property (
		s_rd_taken |=> S_AXI_RVALID)
		else $error("no read answer");
endmodule : phy_data_port_asserts

bind phy_data_port phy_data_port_asserts u_asserts (.*);

// ### testbench/mac_model.sv
// Behavioural MAC transmit side: one fixed frame while go is high.
// Assumes TXC is seen through the core clock.
`timescale 1ns/100ps
module mac_model (
	input  wire logic  i_clk,
	input  wire logic  i_go,
	input  wire logic  i_txc,
	output logic       o_txen,
	output logic [3:0] o_txd
);
	logic [3:0] frame[4] = '{4'h5, 4'h5, 4'hD, 4'hA};
	logic       txc_d = 1'b0;
	int         idx = 0;
	initial o_txen = 1'b0;
	initial o_txd = 4'h0;
	// Moves only on TXC or REF_CLK rise, as a MAC clocked by it would
	always @(posedge i_clk) begin
		txc_d <= i_txc;
		if (i_txc && !txc_d) begin
			if (i_go && idx < 4) begin
				o_txen <= 1'b1;
				o_txd <= frame[idx];
				idx <= idx + 1;
			end else begin
				o_txen <= 1'b0;
				o_txd <= 4'h0;
			end
		end
		if (!i_go)
			idx <= 0;
	end
endmodule : mac_model

// ### testbench/tb_phy_data_port.sv
// Self-checking bench of the PHY data port: MII run, then RMII run.
// Assumes the MAC model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_phy_data_port
	import phy_port_pkg::*;
;
	logic clk, rst_n = 0, xi = 0, lclk = 0, go = 0, txen;
	logic [2:0] cfg = '0, ls = 3'b110;
	line_rx_type lrx = '0;
	line_tx_type lt;
	logic [3:0] txd, rxd, rq[$], tq[$];
	logic [3:0] nib[3] = '{4'h5, 4'hD, 4'hA};
	logic txc, rxc, rxdv, rxer, crs, col, cdv, rck, oe, rc_d, rf_d;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr, arr, bv, rv;
	logic [11:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rdat, r_d;
	logic [1:0] bresp, rresp, r_s;
	int n_fail = 0, check_count = 0;
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always #10 xi = ~xi;
	always #40 lclk = ~lclk;
	phy_data_port uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
		.I_CONFIG(cfg), .I_CRYSTAL_CLOCK_INPUT(xi), .I_TXEN(txen),
		.I_TXD(txd), .O_TXC(txc), .O_RXC(rxc), .O_RXDV(rxdv), .O_RXD(rxd),
		.O_RXER(rxer), .O_CRS(crs), .O_COL(col), .O_CRS_DV(cdv),
		.O_REF_CLK(rck), .O_REF_CLK_OE(oe), .I_LINE_RXCLK(lclk),
		.I_LINE_STATUS(ls), .I_LINE_RX(lrx), .O_LINE_TX(lt),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	// TXC in MII, REF_CLK in RMII: the other one is held low
	mac_model mac (.i_clk(clk), .i_go(go), .i_txc(txc | rck),
		.o_txen(txen), .o_txd(txd));
	// Receive nibbles at RXC fall, dibits at REF_CLK fall: mid-period
	always @(posedge clk) begin
		rc_d <= rxc;
		rf_d <= rck;
		if (!rxc && rc_d && rxdv)
			rq.push_back(rxd);
		if (!rck && rf_d && cdv)
			rq.push_back(rxd);
		if (lt.stb)
			tq.push_back(lt.data);
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{awv, wv, br, awa, wd} <= {w, w, w, a, d};
		{arv, rr, ara} <= {!w, !w, a};
		do begin
			@(posedge clk);
			if (awv && awr)
				awv <= 0;
			if (wv && wr)
				wv <= 0;
			if (arv && arr)
				arv <= 0;
			if (br && bv)
				{br, r_s} <= {1'b0, bresp};
			if (rr && rv)
				{rr, r_s, r_d} <= {1'b0, rresp, rdat};
		end while (awv || wv || br || arv || rr);
	endtask : acc
	task lp(input logic [13:0] v);
		@(posedge clk);
		lrx <= v;
		@(posedge clk);
		lrx <= '0;
	endtask : lp
	task rst(input logic [2:0] c);
		{rst_n, cfg} <= {1'b0, c};
		repeat (8) @(posedge clk);
		rst_n <= 1;
		repeat (10) @(posedge clk);
	endtask : rst
	task finish_test;
		$display("Compared %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	initial begin
		#50000;
		n_fail++;
		finish_test;
	end
	initial begin
		rst(3'h0);
		acc(0, 12'h000, 0);
		chk(r_d, 32'h0A0);
		acc(0, 12'h07C, 0);
		chk(r_d, 32'h0);
		acc(0, 12'h100, 0);
		chk(r_s, 2'h2);
		lp(14'h0200);
		go <= 1;
		for (int i = 0; i < 3; i++) begin
			lp(14'h0040 | nib[i]);
			if (i < 2)
				repeat (14) @(posedge clk);
			// TXEN needs a TXC period plus two sync stages to show
			if (i == 0) begin
				chk(col, 1);
				ls <= 3'b111;
				repeat (2) @(posedge clk);
				chk(col, 0);
				ls <= 3'b110;
			end
		end
		chk(crs, 1);
		lp(14'h0100);
		repeat (40) @(posedge clk);
		chk(crs, 0);
		chk(rq.size(), 3);
		for (int i = 0; i < 3; i++)
			chk(rq[i], nib[i]);
		chk(tq.size(), 4);
		chk({tq[0], tq[1], tq[2], tq[3]}, 16'h55DA);
		go <= 0;
		rst(3'h1);
		rq.delete();
		tq.delete();
		chk(oe, 1);
		acc(0, 12'h000, 0);
		chk(r_d, 32'h0A9);
		lp(14'h0400);
		repeat (2) @(posedge clk);
		chk(cdv, 1);
		chk(rxd, 0);
		go <= 1;
		lp(14'h0059);
		repeat (6) @(posedge clk);
		chk(rxer, 1);
		chk({col, txen & cdv}, 2'h1);
		repeat (6) @(posedge clk);
		lp(14'h0100);
		repeat (20) @(posedge clk);
		chk(cdv, 0);
		chk({tq[0], tq[1]}, 8'h59);
		while (rq.size() > 0 && rq[0] == 0)
			void'(rq.pop_front());
		chk({rq[0], rq[1]}, 8'h12);
		acc(1, 12'h07C, 32'h80);
		chk(oe, 0);
		acc(0, 12'h07C, 0);
		chk(r_d, 32'h80);
		acc(1, 12'h100, 1);
		chk(r_s, 2'h2);
		finish_test;
	end
endmodule : tb_phy_data_port
